/* File: hw/hvme_pkg.sv */
// shared constants for the module event and control register bank
package hvme_pkg;
  localparam int unsigned DW = 32;
  localparam int unsigned NUM_CH = 32;
  // register select codes
  localparam logic [1:0] SEL_EVT_MASK = 2'h0;
  localparam logic [1:0] SEL_CONTROL = 2'h1;
  localparam logic [1:0] SEL_CH_SUM = 2'h2;
  localparam logic [1:0] SEL_CH_MASK = 2'h3;
  // module event bit positions
  localparam int unsigned BIT_TEMP = 14;
  localparam int unsigned BIT_SUPPLY = 13;
  localparam int unsigned BIT_SAFETY = 10;
  localparam int unsigned BIT_INPUT = 6;
  localparam int unsigned BIT_SERVICE = 4;
  localparam logic [31:0] EVT_VALID = 32'h0000_6450;
  localparam logic [31:0] EVT_BLOCKING = 32'h0000_6410;
  // control bit positions
  localparam int unsigned BIT_RAMP_DIS = 16;
  localparam int unsigned BIT_KILL = 14;
  localparam int unsigned BIT_TRIM = 12;
  localparam int unsigned BIT_BIG_END = 11;
  localparam int unsigned BIT_CLEAR = 6;
  // reset values
  localparam logic [31:0] RST_EVT_MASK = 32'h0000_0000;
  localparam logic [31:0] RST_CONTROL = 32'h0000_0800;
  localparam logic [31:0] RST_CH_MASK = 32'h0000_0000;
  localparam logic [31:0] RST_CH_SUM = 32'h0000_0000;
endpackage

/* File: hw/hvme_event_latch.sv */
// sticky event bits with write-one-to-clear and clear-all
`timescale 1ns/1ps
module hvme_event_latch #(
  parameter int unsigned W = 32
) (
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] set_in,
  input  wire logic [W-1:0] valid,
  input  wire logic [W-1:0] w1c,
  input  wire logic         clr_all,
  output logic      [W-1:0] evt
);
  typedef struct packed
  {
    logic [W-1:0] evt;
  } hvme_latch_s;

  hvme_latch_s s_q;
  hvme_latch_s s_d;

  always_comb
  begin
    s_d = s_q;
    if (clr_all)
    begin
      s_d.evt = '0;
    end
    // set wins over a same-cycle clear
    s_d.evt = ((s_d.evt & ~w1c) | set_in) & valid;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      s_q.evt <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign evt = s_q.evt;
endmodule

/* File: hw/hvme_any_masked.sv */
// masked reduction of a pending vector
`timescale 1ns/1ps
module hvme_any_masked #(
  parameter int unsigned W = 32
) (
  input  wire logic [W-1:0] pend,
  input  wire logic [W-1:0] mask,
  output logic              hit,
  output logic      [W-1:0] hits
);
  assign hits = pend & mask;
  assign hit = |hits;
endmodule

/* File: hw/hvme_regs.sv */
// module event mask, control and channel event summary registers
// How it works
// - event mask holds only bits 14,13,10,6,4
// - set mask lets event reach global indication
// - masked blocking event blocks voltage on/raise
// - block raise/turn-on until event or mask clears
// - temp, supply, safety, service block; input not
// - event bit sets on status high, sticky
// - control changes only via trim/kill commands
// - bit 16 disables ramp-rate limitation; never set here, stays zero
// - bit 14 arms kill
// - bit 12 enables fine adjustment
// - bit 11 big endian, always reads one
// - bit 6 clear strobe, reads zero
// - clear-all resets module and channel events
// - summary bit n = latched channel n event, unmasked
// - summary bit cleared by writing one
// - sum flag when masked summary bit set
// - channel mask one bit per channel
`timescale 1ns/1ps
module hvme_regs #(
  parameter int unsigned NUM_CH = hvme_pkg::NUM_CH
) (
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [1:0]        reg_sel,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              trim_config_command,
  input  wire logic              trim_value,
  input  wire logic              kill_config_command,
  input  wire logic              kill_value,
  input  wire logic              clear_status_command,
  input  wire logic [31:0]       module_status,
  input  wire logic [31:0]       module_event_w1c,
  input  wire logic [NUM_CH-1:0] per_channel_event_bit,
  input  wire logic              hv_is_on,
  output logic      [31:0]       reg_rdata,
  output logic                   reg_rvalid,
  output logic      [31:0]       module_event_status,
  output logic                   sum_event_flag,
  output logic                   global_event,
  output logic                   block_raise,
  output logic                   block_turn_on,
  output logic                   kill_armed,
  output logic                   trim_enable,
  output logic                   ramp_limit_disable,
  output logic                   clear_all_pulse
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed
  {
    logic [31:0]       evt_mask;
    logic [31:0]       control;
    logic [NUM_CH-1:0] ch_mask;
    logic [31:0]       rdata;
    logic              rvalid;
    logic              gevt;
    logic              blk_raise;
    logic              blk_on;
    logic              sum_flag;
    logic              clr;
  } hvme_regs_s;

  hvme_regs_s s_q;
  hvme_regs_s s_d;

  logic [31:0]       evt_q;
  logic [NUM_CH-1:0] ch_sum_q;
  logic [NUM_CH-1:0] ch_w1c;
  logic [NUM_CH-1:0] ch_hits;
  logic              ch_any;
  logic [31:0]       evt_hits;
  logic              evt_any;
  logic              clr_now;

  function automatic logic sel_hit(input logic [1:0] sel, input logic [1:0] code);
    sel_hit = (sel == code);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // clear-all from the clear command only; a bit 6 write does not clear
  assign clr_now = clear_status_command;
  assign ch_w1c = (reg_wr && sel_hit(reg_sel, hvme_pkg::SEL_CH_SUM)) ? reg_wdata[NUM_CH-1:0] : '0;

  hvme_event_latch #(
    .W (32)
  ) u_mod_evt (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .set_in  (module_status),
    .valid   (hvme_pkg::EVT_VALID),
    .w1c     (module_event_w1c),
    .clr_all (clr_now),
    .evt     (evt_q)
  );

  hvme_event_latch #(
    .W (NUM_CH)
  ) u_ch_sum (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .set_in  (per_channel_event_bit),
    .valid   ({NUM_CH{1'b1}}),
    .w1c     (ch_w1c),
    .clr_all (clr_now),
    .evt     (ch_sum_q)
  );

  hvme_any_masked #(
    .W (NUM_CH)
  ) u_ch_any (
    .pend (ch_sum_q),
    .mask (s_q.ch_mask),
    .hit  (ch_any),
    .hits (ch_hits)
  );

  hvme_any_masked #(
    .W (32)
  ) u_evt_any (
    .pend (evt_q),
    .mask (s_q.evt_mask),
    .hit  (evt_any),
    .hits (evt_hits)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    s_d.clr = clr_now;
    if (reg_wr)
    begin
      if (sel_hit(reg_sel, hvme_pkg::SEL_EVT_MASK))
      begin
        s_d.evt_mask = reg_wdata & hvme_pkg::EVT_VALID;
      end
      else if (sel_hit(reg_sel, hvme_pkg::SEL_CH_MASK))
      begin
        s_d.ch_mask = reg_wdata[NUM_CH-1:0];
      end
      // control register has no direct write path
    end
    if (trim_config_command)
    begin
      s_d.control[hvme_pkg::BIT_TRIM] = trim_value;
    end
    if (kill_config_command)
    begin
      s_d.control[hvme_pkg::BIT_KILL] = kill_value;
    end
    s_d.control[hvme_pkg::BIT_BIG_END] = 1'b1;
    s_d.control[hvme_pkg::BIT_CLEAR] = 1'b0;
    if (reg_rd)
    begin
      s_d.rvalid = 1'b1;
      if (sel_hit(reg_sel, hvme_pkg::SEL_EVT_MASK))
      begin
        s_d.rdata = s_q.evt_mask;
      end
      else if (sel_hit(reg_sel, hvme_pkg::SEL_CONTROL))
      begin
        s_d.rdata = s_q.control;
      end
      else if (sel_hit(reg_sel, hvme_pkg::SEL_CH_SUM))
      begin
        s_d.rdata = 32'(ch_sum_q);
      end
      else
      begin
        s_d.rdata = 32'(s_q.ch_mask);
      end
    end
    s_d.gevt = evt_any;
    // blocking-type events only, lifted when event or mask clears
    s_d.blk_raise = |(evt_hits & hvme_pkg::EVT_BLOCKING) & hv_is_on;
    s_d.blk_on = |(evt_hits & hvme_pkg::EVT_BLOCKING) & ~hv_is_on;
    s_d.sum_flag = ch_any;
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      s_q.evt_mask <= hvme_pkg::RST_EVT_MASK;
      s_q.control <= hvme_pkg::RST_CONTROL;
      s_q.ch_mask <= NUM_CH'(hvme_pkg::RST_CH_MASK);
      s_q.rdata <= 32'h0000_0000;
      s_q.rvalid <= 1'b0;
      s_q.gevt <= 1'b0;
      s_q.blk_raise <= 1'b0;
      s_q.blk_on <= 1'b0;
      s_q.sum_flag <= 1'b0;
      s_q.clr <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign reg_rdata = s_q.rdata;
  assign reg_rvalid = s_q.rvalid;
  assign module_event_status = evt_q;
  assign sum_event_flag = s_q.sum_flag;
  assign global_event = s_q.gevt;
  assign block_raise = s_q.blk_raise;
  assign block_turn_on = s_q.blk_on;
  assign kill_armed = s_q.control[hvme_pkg::BIT_KILL];
  assign trim_enable = s_q.control[hvme_pkg::BIT_TRIM];
  assign ramp_limit_disable = s_q.control[hvme_pkg::BIT_RAMP_DIS];
  assign clear_all_pulse = s_q.clr;
endmodule

/* File: tb/hvme_regs_props.sv */
// assertions on the register bank ports
`timescale 1ns/1ps
module hvme_props_chk (
  input wire logic        mclk,
  input wire logic        sys_rst,
  input wire logic        reg_rd,
  input wire logic [1:0]  reg_sel,
  input wire logic        kill_config_command,
  input wire logic        kill_value,
  input wire logic        clear_status_command,
  input wire logic        hv_is_on,
  input wire logic [31:0] reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic [31:0] module_event_status,
  input wire logic        global_event,
  input wire logic        block_raise,
  input wire logic        block_turn_on,
  input wire logic        kill_armed,
  input wire logic        ramp_limit_disable,
  input wire logic        clear_all_pulse
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);
  rd_valid_a: assert property (reg_rd |=> reg_rvalid) else $error("no read valid");
  ctl_read_a: assert property (reg_rd && reg_sel == 2'h1 |=> reg_rdata[11] && !reg_rdata[6] &&
    reg_rdata[14] == $past(kill_armed) && reg_rdata[16] == $past(ramp_limit_disable)) else $error("bad control read");
  evt_bits_a: assert property ((module_event_status & ~hvme_pkg::EVT_VALID) == 0) else $error("bad event bit");
  kill_cmd_a: assert property (kill_config_command |=> kill_armed == $past(kill_value)) else $error("kill");
  clr_pulse_a: assert property (clear_status_command |=> clear_all_pulse) else $error("no clear");
  raise_blk_a: assert property (block_raise |-> $past(hv_is_on) &&
    ($past(module_event_status) & hvme_pkg::EVT_BLOCKING) != 0) else $error("bad raise block");
  on_blk_a: assert property (block_turn_on |-> !$past(hv_is_on) &&
    ($past(module_event_status) & hvme_pkg::EVT_BLOCKING) != 0) else $error("bad turn-on block");
  glob_evt_a: assert property (global_event |-> $past(module_event_status) != 0) else $error("bad global");
endmodule

/* File: tb/tb_top.sv */
// self-checking bench for the register bank
`timescale 1ns/1ps
module tb_top;
  logic        mclk, sys_rst, reg_wr, reg_rd, trim_config_command, trim_value;
  logic        kill_config_command, kill_value, clear_status_command, hv_is_on;
  logic [1:0]  reg_sel;
  logic [31:0] reg_wdata, module_status, module_event_w1c, per_channel_event_bit;
  logic [31:0] reg_rdata, module_event_status;
  logic        reg_rvalid, sum_event_flag, global_event, block_raise, block_turn_on;
  logic        kill_armed, trim_enable, ramp_limit_disable, clear_all_pulse;
  logic [31:0] s = 32'h46, m, p, w;
  int          n_errors = 0, checked = 0;
  int unsigned bt[5] = '{hvme_pkg::BIT_TEMP, hvme_pkg::BIT_SUPPLY, hvme_pkg::BIT_SAFETY,
                         hvme_pkg::BIT_INPUT, hvme_pkg::BIT_SERVICE};
  hvme_regs i_dut (.*);
  function automatic logic [31:0] rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [31:0] ctl(logic k, logic t);
    return hvme_pkg::RST_CONTROL | {17'h0, k, 1'b0, t, 12'h0};
  endfunction
  task automatic chk(logic [31:0] g, logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(logic [1:0] a, logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_sel <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [1:0] a, logic [31:0] e);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_sel <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(32'(reg_rvalid), 32'h1);
    chk(reg_rdata, e);
  endtask
  task automatic end_sim();
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial
  begin
    #50000;
    n_errors++;
    end_sim();
  end
  initial
  begin
    {sys_rst, reg_wr, reg_rd, trim_config_command, trim_value, kill_config_command, kill_value} = 7'h40;
    {clear_status_command, hv_is_on, reg_sel} = 4'h0;
    {reg_wdata, module_status, module_event_w1c, per_channel_event_bit} = 128'h0;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(0, 32'h0);
    rd(1, hvme_pkg::RST_CONTROL);
    rd(2, 32'h0);
    rd(3, 32'h0);
    wr(0, 32'hffffffff);
    rd(0, hvme_pkg::EVT_VALID);
    wr(1, 32'hffffffff);
    rd(1, hvme_pkg::RST_CONTROL);
    for (int i = 0; i < 8; i++)
    begin
      m = rnd();
      p = rnd();
      w = rnd();
      // drop summary bits left by the previous pass
      wr(2, 32'hffffffff);
      @(posedge mclk);
      {kill_config_command, trim_config_command} <= 2'h3;
      {kill_value, trim_value} <= m[1:0];
      @(posedge mclk);
      {kill_config_command, trim_config_command} <= 2'h0;
      rd(1, ctl(m[1], m[0]));
      chk(32'({ramp_limit_disable, kill_armed, trim_enable}), 32'({1'b0, m[1:0]}));
      wr(0, m);
      rd(0, m & hvme_pkg::EVT_VALID);
      wr(3, ~m);
      rd(3, ~m);
      @(posedge mclk);
      per_channel_event_bit <= p;
      @(posedge mclk);
      per_channel_event_bit <= '0;
      rd(2, p);
      chk(32'(sum_event_flag), 32'(|(p & ~m)));
      wr(2, w);
      rd(2, p & ~w);
      chk(32'(sum_event_flag), 32'(|(p & ~w & ~m)));
    end
    // each module event: latch, indicate, block unless input, then unmask and clear
    for (int i = 0; i < 5; i++)
    begin
      w = 32'h1 << bt[i];
      wr(0, w);
      @(posedge mclk);
      module_status <= w;
      hv_is_on <= i[0];
      @(posedge mclk);
      module_status <= '0;
      repeat (2) @(posedge mclk);
      #1;
      chk(module_event_status, w);
      chk(32'(global_event), 32'h1);
      chk(32'(block_raise), 32'(i[0] && (w & hvme_pkg::EVT_BLOCKING) != 0));
      chk(32'(block_turn_on), 32'(!i[0] && (w & hvme_pkg::EVT_BLOCKING) != 0));
      wr(0, 32'h0);
      @(posedge mclk);
      module_event_w1c <= w;
      @(posedge mclk);
      module_event_w1c <= '0;
      #1;
      chk(32'({global_event, block_raise, block_turn_on}), 32'h0);
      chk(module_event_status, 32'h0);
    end
    @(posedge mclk);
    {module_status, per_channel_event_bit} <= '1;
    @(posedge mclk);
    {module_status, per_channel_event_bit} <= '0;
    clear_status_command <= 1'b1;
    @(posedge mclk);
    clear_status_command <= 1'b0;
    #1;
    chk(module_event_status, 32'h0);
    chk(32'(clear_all_pulse), 32'h1);
    rd(2, 32'h0);
    end_sim();
  end
endmodule
bind hvme_regs hvme_props_chk i_chk (.*);
